// ==== pkg/bmmc_pkg.sv ====
/*
  Constants for the boot memory map control block: address windows, register
  offsets, field positions, reset values and response codes.
  Assumes a 16-bit MCU address space and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none
package bmmc_pkg;
  // ---------------------------------------------------------------------
  // Address windows
  // ---------------------------------------------------------------------
  localparam logic [15:0] BMMC_ROM_LO = 16'h0000;
  localparam logic [15:0] BMMC_ROM_HI = 16'h17ff;
  localparam logic [15:0] BMMC_ROM_DUP_LO = 16'h8000;
  localparam logic [15:0] BMMC_ROM_DUP_HI = 16'h97ff;
  localparam logic [15:0] BMMC_RAM_LO = 16'h0000;
  localparam logic [15:0] BMMC_RAM_HI = 16'h1fff;
  localparam logic [15:0] BMMC_IO_LO = 16'hfd80;
  localparam logic [15:0] BMMC_IO_HI = 16'hffff;
  localparam logic [15:0] BMMC_RESET_VECTOR = 16'h0000;
  localparam int BMMC_MEM_AW = 13;
  localparam int BMMC_MEM_DEPTH = 8192;
  // ---------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------
  localparam int BMMC_AXI_AW = 4;
  localparam logic [3:0] BMMC_OFF_CFG = 4'h0;
  localparam logic [3:0] BMMC_OFF_BUSCTL = 4'h4;
  localparam logic [3:0] BMMC_OFF_CLK = 4'h8;
  localparam logic [1:0] BMMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] BMMC_RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int BMMC_CFG_MAP = 0;
  localparam int BMMC_CFG_REV_LSB = 1;
  localparam int BMMC_CFG_REV_MSB = 4;
  localparam int BMMC_CFG_RESERVED5 = 5;
  localparam int BMMC_CFG_INT_SEL = 6;
  localparam int BMMC_CFG_RESERVED7 = 7;
  localparam int BMMC_BUSCTL_CONNECT = 0;
  localparam int BMMC_CLK_EXT48 = 0;
  localparam int BMMC_CLK_TEST = 1;
  localparam int BMMC_CLK_STRAP_LSB = 2;
  localparam logic BMMC_MAP_RESET = 1'b0;
  localparam logic BMMC_INT_SEL_RESET = 1'b0;
  localparam logic BMMC_CONNECT_RESET = 1'b0;
  localparam logic [1:0] BMMC_STRAP_EXT48 = 2'h0;
  localparam logic [1:0] BMMC_STRAP_CRYSTAL = 2'h3;
endpackage
`default_nettype wire

// ==== hw/bmmc_ram.sv ====
/*
  Single-port 8K x 8 RAM with a registered read port.
  Assumes one access per enabled cycle; write data is not forwarded.
*/
`timescale 1ns/1ps
`default_nettype none
module bmmc_ram
  import bmmc_pkg::*;
(
  input wire logic aclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [BMMC_MEM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // ---------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------
  logic [7:0] mem [0:BMMC_MEM_DEPTH-1];

  // Contents are undefined at power-up, as for any real RAM
  always_ff @(posedge aclk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule // bmmc_ram
`default_nettype wire

// ==== hw/bmmc_top.sv ====
/*
  Boot memory map control: configuration register over AXI4-Lite, code and
  data space decoding, the 8K RAM, interrupt line one select, clock straps.
  Assumes the MCU core issues at most one code and one data access per cycle
  and an external boot ROM takes its address from code_rom_addr.
*/
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bmmc_top
  import bmmc_pkg::*;
#(
  // Revision value is arbitrary
  parameter logic [3:0] REVISION = 4'h1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic function_reset,
  input wire logic clock_strap_low,
  input wire logic clock_strap_high,
  input wire logic port3_bit3_pin,
  input wire logic [7:0] port2_in,
  input wire logic code_req,
  input wire logic [15:0] code_addr,
  input wire logic data_req,
  input wire logic data_we,
  input wire logic [15:0] data_addr,
  input wire logic [7:0] data_wdata,
  input wire logic [BMMC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [BMMC_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic code_valid,
  output logic code_from_rom,
  output logic code_from_ram,
  output logic [BMMC_MEM_AW-1:0] code_rom_addr,
  output logic data_valid,
  output logic data_ram_hit,
  output logic data_io_hit,
  output logic data_write_blocked,
  output logic [7:0] mem_rdata,
  output logic boot_done_map_bit,
  output logic bus_connect_bit,
  output logic external_interrupt_line_one,
  output logic clk_select_ext48,
  output logic clk_select_crystal,
  output logic clk_test_mode
);
  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  logic int_line_source_select;
  logic strap_caught;
  logic [1:0] strap_value;
  logic aw_full;
  logic w_full;
  logic [BMMC_AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic rd_was_cfg;
  logic first_fetch_pending;

  // ---------------------------------------------------------------------
  // Code and data space decode
  // ---------------------------------------------------------------------
  wire code_in_boot_lo = code_addr >= BMMC_ROM_LO && code_addr <= BMMC_ROM_HI;
  wire code_in_boot_dup = code_addr >= BMMC_ROM_DUP_LO && code_addr <= BMMC_ROM_DUP_HI;
  wire code_in_ram_win = code_addr >= BMMC_RAM_LO && code_addr <= BMMC_RAM_HI;
  wire data_in_ram_win = data_addr >= BMMC_RAM_LO && data_addr <= BMMC_RAM_HI;
  wire data_in_io_win = data_addr >= BMMC_IO_LO && data_addr <= BMMC_IO_HI;
  // Decode uses the map bit as it stands when the fetch is taken
  wire next_code_rom = boot_done_map_bit ? code_in_boot_dup :
    (code_in_boot_lo || code_in_boot_dup);
  wire next_code_ram = boot_done_map_bit && code_in_ram_win;
  wire next_data_ram = !boot_done_map_bit && data_in_ram_win;
  wire next_data_io = data_in_io_win;
  // RAM lives in exactly one space at a time, so one port serves both
  wire [BMMC_MEM_AW-1:0] ram_addr = boot_done_map_bit ?
    code_addr[BMMC_MEM_AW-1:0] : data_addr[BMMC_MEM_AW-1:0];
  wire ram_we = data_req && data_we && next_data_ram;
  wire next_blocked = data_req && data_we && boot_done_map_bit && data_in_ram_win;

  // ---------------------------------------------------------------------
  // Register bus decode
  // ---------------------------------------------------------------------
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire do_write = (aw_full || aw_take) && (w_full || w_take) && !s_axi_bvalid;
  wire [BMMC_AXI_AW-1:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr_q;
  wire [31:0] wr_data = w_take ? s_axi_wdata : w_data_q;
  wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb_q;
  wire [3:0] wr_word = {wr_addr[BMMC_AXI_AW-1:2], 2'h0};
  wire [3:0] rd_word = {s_axi_araddr[BMMC_AXI_AW-1:2], 2'h0};
  wire wr_cfg = do_write && wr_word == BMMC_OFF_CFG && wr_strb[0];
  wire wr_busctl = do_write && wr_word == BMMC_OFF_BUSCTL && wr_strb[0];
  wire wr_mapped = wr_word == BMMC_OFF_CFG || wr_word == BMMC_OFF_BUSCTL ||
    wr_word == BMMC_OFF_CLK;
  wire rd_mapped = rd_word == BMMC_OFF_CFG || rd_word == BMMC_OFF_BUSCTL ||
    rd_word == BMMC_OFF_CLK;
  wire next_aw_full = (aw_full || aw_take) && !do_write;
  wire next_w_full = (w_full || w_take) && !do_write;
  wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
  wire next_awready = !next_aw_full && !next_bvalid;
  wire next_wready = !next_w_full && !next_bvalid;
  wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
  wire next_arready = !next_rvalid;
  // Reserved bits 5 and 7 are tied low; revision is not stored at all
  wire [7:0] cfg_value = {1'b0, int_line_source_select, 1'b0,
    REVISION, boot_done_map_bit};
  wire [31:0] busctl_value = {31'h0, bus_connect_bit};
  wire [31:0] clk_value = {28'h0, strap_value, clk_test_mode, clk_select_ext48};
  wire [31:0] next_rdata = rd_word == BMMC_OFF_CFG ? {24'h0, cfg_value} :
    rd_word == BMMC_OFF_BUSCTL ? busctl_value :
    rd_word == BMMC_OFF_CLK ? clk_value : 32'h0;
  wire next_int_line = int_line_source_select ? |port2_in : port3_bit3_pin;
  wire [1:0] strap_pins = {clock_strap_high, clock_strap_low};

  // ---------------------------------------------------------------------
  // RAM
  // ---------------------------------------------------------------------
  bmmc_ram u_ram (
    .aclk(aclk),
    .ce(ce),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(data_wdata),
    .rdata(mem_rdata)
  );

  // ---------------------------------------------------------------------
  // AXI4-Lite handshake
  // ---------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BMMC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= BMMC_RESP_OKAY;
      s_axi_rdata <= 32'h0;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      rd_was_cfg <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= wr_mapped ? BMMC_RESP_OKAY : BMMC_RESP_SLVERR;
      end
      if (ar_take) begin
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= rd_mapped ? BMMC_RESP_OKAY : BMMC_RESP_SLVERR;
        rd_was_cfg <= rd_word == BMMC_OFF_CFG;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Configuration and bus control bits
  // ---------------------------------------------------------------------
  // Writing zero to the map bit does nothing; only a reset takes it back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_done_map_bit <= BMMC_MAP_RESET;
      bus_connect_bit <= BMMC_CONNECT_RESET;
      int_line_source_select <= BMMC_INT_SEL_RESET;
    end else if (ce) begin
      if (function_reset) begin
        boot_done_map_bit <= BMMC_MAP_RESET;
        bus_connect_bit <= BMMC_CONNECT_RESET;
        int_line_source_select <= BMMC_INT_SEL_RESET;
      end else begin
        if (wr_cfg) begin
          boot_done_map_bit <= boot_done_map_bit | wr_data[BMMC_CFG_MAP];
          int_line_source_select <= wr_data[BMMC_CFG_INT_SEL];
        end
        if (wr_busctl) begin
          bus_connect_bit <= wr_data[BMMC_BUSCTL_CONNECT];
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Clock straps, caught once after reset release
  // ---------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_caught <= 1'b0;
      strap_value <= BMMC_STRAP_CRYSTAL;
      clk_select_ext48 <= 1'b0;
      clk_select_crystal <= 1'b1;
      clk_test_mode <= 1'b0;
    end else if (ce && !strap_caught) begin
      strap_caught <= 1'b1;
      strap_value <= strap_pins;
      clk_select_ext48 <= strap_pins == BMMC_STRAP_EXT48;
      clk_select_crystal <= strap_pins == BMMC_STRAP_CRYSTAL;
      clk_test_mode <= strap_pins != BMMC_STRAP_EXT48 &&
        strap_pins != BMMC_STRAP_CRYSTAL;
    end
  end

  // ---------------------------------------------------------------------
  // Access results and interrupt line
  // ---------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_valid <= 1'b0;
      code_from_rom <= 1'b0;
      code_from_ram <= 1'b0;
      code_rom_addr <= 13'h0;
      data_valid <= 1'b0;
      data_ram_hit <= 1'b0;
      data_io_hit <= 1'b0;
      data_write_blocked <= 1'b0;
      external_interrupt_line_one <= 1'b0;
    end else if (ce) begin
      code_valid <= code_req;
      code_from_rom <= code_req && next_code_rom;
      code_from_ram <= code_req && next_code_ram;
      // ROM window offsets share the low address bits in both images
      code_rom_addr <= code_addr[BMMC_MEM_AW-1:0];
      data_valid <= data_req;
      data_ram_hit <= data_req && next_data_ram;
      data_io_hit <= data_req && next_data_io;
      data_write_blocked <= next_blocked;
      external_interrupt_line_one <= next_int_line;
    end
  end

  // Helper for the first fetch check only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_fetch_pending <= 1'b1;
    end else if (ce && code_req) begin
      first_fetch_pending <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_strap_clock_select: assert property (
    strap_caught |-> (clk_select_ext48 == (strap_value == BMMC_STRAP_EXT48)) &&
      (clk_select_crystal == (strap_value == BMMC_STRAP_CRYSTAL)) &&
      (clk_test_mode == !(clk_select_ext48 || clk_select_crystal)))
    else $error("clock select does not match strap value");

  a_boot_rom_fetch: assert property (
    ce && code_req && !boot_done_map_bit && (code_in_boot_lo || code_in_boot_dup)
      |=> code_valid && code_from_rom && !code_from_ram)
    else $error("boot mode fetch not served from rom");

  a_boot_ram_data: assert property (
    ce && data_req && !boot_done_map_bit && data_in_ram_win
      |=> data_valid && data_ram_hit)
    else $error("boot mode data access missed ram");

  a_normal_map_decode: assert property (
    ce && code_req && boot_done_map_bit
      |=> code_from_ram == $past(code_in_ram_win) &&
        code_from_rom == $past(code_in_boot_dup))
    else $error("normal mode code decode wrong");

  a_io_window_hit: assert property (
    ce && data_req |=> data_io_hit == $past(data_addr >= BMMC_IO_LO))
    else $error("io window decode wrong");

  a_ram_write_block: assert property (
    boot_done_map_bit |-> !ram_we)
    else $error("ram written while mapped to code space");

  a_blocked_write_flag: assert property (
    ce && data_req && data_we && boot_done_map_bit && data_addr <= BMMC_RAM_HI
      |=> data_write_blocked && !data_ram_hit)
    else $error("blocked write not flagged");

  a_reset_clears_bits: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> !boot_done_map_bit && !bus_connect_bit)
    else $error("reset left map or connect bit set");

  a_first_fetch_rom: assert property (
    ce && code_req && first_fetch_pending && code_addr == BMMC_RESET_VECTOR
      |=> code_from_rom)
    else $error("first fetch not from boot rom");

  a_map_bit_sticky: assert property (
    boot_done_map_bit && !function_reset |=> boot_done_map_bit)
    else $error("map bit cleared without reset");

  a_map_bit_sets: assert property (
    ce && !function_reset && wr_cfg && wr_data[BMMC_CFG_MAP]
      |=> boot_done_map_bit ##1 boot_done_map_bit)
    else $error("map bit not set by write");

  a_rev_read_only: assert property (
    s_axi_rvalid && rd_was_cfg
      |-> s_axi_rdata[BMMC_CFG_REV_MSB:BMMC_CFG_REV_LSB] == REVISION)
    else $error("revision field wrong on read");

  a_int_line_source: assert property (
    ce && $stable(int_line_source_select) |=>
      external_interrupt_line_one ==
        $past(int_line_source_select ? |port2_in : port3_bit3_pin))
    else $error("interrupt line source wrong");

  a_reserved_read_zero: assert property (
    s_axi_rvalid && rd_was_cfg
      |-> !s_axi_rdata[BMMC_CFG_RESERVED5] && !s_axi_rdata[BMMC_CFG_RESERVED7])
    else $error("reserved config bit read as one");

  a_map_next_fetch: assert property (
    ce && code_req && $rose(boot_done_map_bit) && code_in_boot_lo
      |=> code_from_ram && !code_from_rom)
    else $error("map change not applied to next fetch");

  a_fetch_not_dropped: assert property (
    ce && code_req |=> code_valid)
    else $error("code fetch dropped");
endmodule // bmmc_top
`default_nettype wire

// ==== sim/bmmc_mcu_model.sv ====
/*
  Behavioural MCU core for the boot memory map block: code fetches and data accesses.
  Assumes its tasks are called from one process and that aclk runs freely.
*/
`timescale 1ns/1ps
`default_nettype none
module bmmc_mcu_model (
  input wire logic aclk,
  output logic code_req,
  output logic [15:0] code_addr,
  output logic data_req,
  output logic data_we,
  output logic [15:0] data_addr,
  output logic [7:0] data_wdata
);
  // ---------------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------------
  initial begin
    code_req = 1'b0;
    code_addr = 16'h5a5a;
    data_req = 1'b0;
    data_we = 1'b0;
    data_addr = 16'ha5a5;
    data_wdata = 8'h3c;
  end
  // ---------------------------------------------------------------------
  // Requests
  // ---------------------------------------------------------------------
  // Released lines are inverted so a stale address can never pass as valid
  task automatic fetch(input logic [15:0] a);
    @(posedge aclk);
    code_req <= 1'b1;
    code_addr <= a;
    @(posedge aclk);
    code_req <= 1'b0;
    code_addr <= ~a;
    #1;
  endtask
  // Holds one fetch address over several edges, as back-to-back fetches do
  task automatic hold(input logic [15:0] a, input int n);
    @(posedge aclk);
    code_req <= 1'b1;
    code_addr <= a;
    repeat (n) @(posedge aclk);
    code_req <= 1'b0;
    code_addr <= ~a;
    #1;
  endtask
  // Boot firmware loads the RAM through data space before the map switch
  task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk);
    data_req <= 1'b1;
    data_we <= we;
    data_addr <= a;
    data_wdata <= d;
    @(posedge aclk);
    data_req <= 1'b0;
    data_we <= ~we;
    data_addr <= ~a;
    data_wdata <= ~d;
    #1;
  endtask
endmodule // bmmc_mcu_model
`default_nettype wire

// ==== sim/tb_boot_memory_map_control.sv ====
/*
  Self-checking bench for the boot memory map block: straps, map modes, RAM load,
  configuration register over AXI4-Lite, interrupt select and function reset.
  Assumes the register offsets and one-cycle port timing of the design package.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_boot_memory_map_control
  import bmmc_pkg::*;
;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  localparam logic [3:0] REV = 4'ha; // Revision value is arbitrary
  logic aclk, aresetn, ce, function_reset, clock_strap_low, clock_strap_high, port3_bit3_pin;
  logic [7:0] port2_in, data_wdata, mem_rdata;
  logic code_req, data_req, data_we;
  logic [15:0] code_addr, data_addr;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic code_valid, code_from_rom, code_from_ram, data_valid, data_ram_hit, data_io_hit;
  logic data_write_blocked, boot_done_map_bit, bus_connect_bit, external_interrupt_line_one;
  logic clk_select_ext48, clk_select_crystal, clk_test_mode;
  logic [BMMC_MEM_AW-1:0] code_rom_addr;
  logic [31:0] rnd = 32'hc240d52b;
  logic [7:0] img [int];
  int err_total = 0;
  int samples_checked = 0;
  bmmc_top #(.REVISION(REV)) dut (.*);
  bmmc_mcu_model mcu (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // ---------------------------------------------------------------------
  // Expectations and checks
  // ---------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] fetch_exp(input logic m, input logic [15:0] a);
    logic dup;
    dup = a >= BMMC_ROM_DUP_LO && a <= BMMC_ROM_DUP_HI;
    return m ? {dup, a <= BMMC_RAM_HI} : {a <= BMMC_ROM_HI || dup, 1'b0};
  endfunction
  function automatic logic [31:0] cfg_exp(input logic m, input logic x);
    return 32'({1'b0, x, 1'b0, REV, m});
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------
  // Bus and port tasks
  // ---------------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  // Fixed boundary addresses first, then random ones
  task automatic do_fetch(input logic m);
    logic [15:0] fa [10] = '{16'h0000, 16'h17ff, 16'h1800, 16'h1fff, 16'h2000,
                             16'h7fff, 16'h8000, 16'h97ff, 16'h9800, 16'hffff};
    logic [15:0] a;
    for (int i = 0; i < 14; i++) begin
      rnd = lfsr(rnd);
      a = i < 10 ? fa[i] : rnd[15:0];
      mcu.fetch(a);
      chk(32'(code_valid), 32'h1);
      chk(32'({code_from_rom, code_from_ram}), 32'(fetch_exp(m, a)));
      if (code_from_rom) chk(32'(code_rom_addr), 32'(a[12:0]));
    end
  endtask
  task automatic int_chk(input logic xs);
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      @(posedge aclk);
      port3_bit3_pin <= rnd[0];
      port2_in <= rnd[9] ? rnd[17:10] : 8'h00;
      repeat (2) @(posedge aclk);
      #1;
      chk(32'(external_interrupt_line_one), 32'(xs ? |port2_in : port3_bit3_pin));
    end
  endtask
  // ---------------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    summarize;
  end
  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] a;
    logic [15:0] io [3] = '{16'hfd7f, 16'hfd80, 16'hffff};
    {aresetn, ce, function_reset, port3_bit3_pin, port2_in} = {2'b01, 2'b00, 8'h00};
    {clock_strap_high, clock_strap_low, s_axi_wstrb} = {2'b11, 4'hf};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    for (int s = 0; s < 4; s++) begin
      {clock_strap_high, clock_strap_low} <= 2'(s);
      do_reset;
      chk(32'({clk_select_ext48, clk_test_mode, clk_select_crystal}),
          32'({s == 0, s == 1 || s == 2, s == 3}));
      axi_rd(BMMC_OFF_CLK, d, r);
      chk(d, 32'({2'(s), s == 1 || s == 2, s == 0}));
    end
    chk(32'({boot_done_map_bit, bus_connect_bit}), 32'h0);
    axi_rd(BMMC_OFF_CFG, d, r);
    chk(d, cfg_exp(1'b0, 1'b0));
    axi_rd(BMMC_OFF_BUSCTL, d, r);
    chk(d, 32'h0);
    axi_rd(4'hc, d, r);
    chk({d[29:0], r}, {30'h0, BMMC_RESP_SLVERR});
    axi_wr(4'hc, 32'hffffffff, r);
    chk(32'(r), 32'(BMMC_RESP_SLVERR));
    do_fetch(1'b0);
    for (int k = 0; k < 16; k++) begin
      rnd = lfsr(rnd);
      a = k == 0 ? 16'h0000 : (k == 1 ? 16'h1fff : {3'h0, rnd[12:0]});
      img[a] = rnd[20:13];
      mcu.access(1'b1, a, rnd[20:13]);
    end
    foreach (img[i]) begin
      mcu.access(1'b0, 16'(i), 8'h00);
      chk(32'({data_valid, data_ram_hit, data_io_hit, mem_rdata}), {21'h0, 3'h6, img[i]});
    end
    foreach (io[i]) begin
      mcu.access(1'b0, io[i], 8'h00);
      chk(32'(data_io_hit), 32'(i > 0));
    end
    int_chk(1'b0);
    @(posedge aclk);
    ce <= 1'b0;
    port3_bit3_pin <= ~port3_bit3_pin;
    repeat (3) @(posedge aclk);
    #1;
    chk(32'(external_interrupt_line_one), 32'(!port3_bit3_pin));
    ce <= 1'b1;
    fork
      axi_wr(BMMC_OFF_CFG, 32'hff, r);
      mcu.hold(16'h0000, 4);
    join
    chk(32'({code_from_rom, code_from_ram}), 32'h1);
    chk(32'(r), 32'(BMMC_RESP_OKAY));
    do_fetch(1'b1);
    axi_rd(BMMC_OFF_CFG, d, r);
    chk(d, cfg_exp(1'b1, 1'b1));
    int_chk(1'b1);
    axi_wr(BMMC_OFF_CFG, 32'h0, r);
    axi_rd(BMMC_OFF_CFG, d, r);
    chk(d, cfg_exp(1'b1, 1'b0));
    foreach (img[i]) begin
      mcu.fetch(16'(i));
      chk(32'(mem_rdata), 32'(img[i]));
    end
    mcu.access(1'b1, 16'h0000, ~img[0]);
    chk(32'({data_write_blocked, data_ram_hit, data_io_hit}), 32'h4);
    mcu.fetch(16'h0000);
    chk(32'(mem_rdata), 32'(img[0]));
    axi_wr(BMMC_OFF_BUSCTL, 32'h1, r);
    axi_rd(BMMC_OFF_BUSCTL, d, r);
    chk(d, 32'h1);
    chk(32'(bus_connect_bit), 32'h1);
    @(posedge aclk);
    function_reset <= 1'b1;
    @(posedge aclk);
    function_reset <= 1'b0;
    @(posedge aclk);
    #1;
    chk(32'({boot_done_map_bit, bus_connect_bit}), 32'h0);
    mcu.fetch(BMMC_RESET_VECTOR);
    chk(32'({code_from_rom, code_from_ram}), 32'h2);
    s_axi_wstrb <= 4'he;
    axi_wr(BMMC_OFF_CFG, 32'h41, r);
    s_axi_wstrb <= 4'hf;
    chk(32'(r), 32'(BMMC_RESP_OKAY));
    axi_rd(BMMC_OFF_CFG, d, r);
    chk(d, cfg_exp(1'b0, 1'b0));
    axi_wr(BMMC_OFF_CFG, 32'h1, r);
    axi_wr(BMMC_OFF_BUSCTL, 32'h1, r);
    do_reset;
    chk(32'({boot_done_map_bit, bus_connect_bit}), 32'h0);
    mcu.fetch(BMMC_RESET_VECTOR);
    chk(32'({code_from_rom, code_from_ram}), 32'h2);
    summarize;
  end
endmodule // tb_boot_memory_map_control
`default_nettype wire
